// ---- common/prd_pkg.sv ----
// Constants shared by the pulse reference decoder files.
// Assumes a single 100 MHz clock domain with synchronous active-high reset.
package prd_pkg;

  localparam int DEV_W = 32;

  // Reference pulse form selection codes.
  localparam logic [3:0] FMT_STEP_DIR_POS = 4'h0;
  localparam logic [3:0] FMT_FWD_REV_POS = 4'h1;
  localparam logic [3:0] FMT_QUAD_X1 = 4'h2;
  localparam logic [3:0] FMT_QUAD_X2 = 4'h3;
  localparam logic [3:0] FMT_QUAD_X4 = 4'h4;
  localparam logic [3:0] FMT_STEP_DIR_NEG = 4'h5;
  localparam logic [3:0] FMT_FWD_REV_NEG = 4'h6;

  // Clear input mode codes.
  localparam logic [1:0] CLR_WHILE_ON = 2'h0;
  localparam logic [1:0] CLR_ON_RISE = 2'h1;
  localparam logic [1:0] CLR_WHILE_OFF = 2'h2;

  // Alarm clear option codes.
  localparam logic [1:0] ALM_CLEARS = 2'h0;
  localparam logic [1:0] ALM_KEEPS = 2'h1;

  localparam logic [DEV_W-1:0] DEV_RESET = 32'h0000_0000;
  localparam logic [1:0] PIN_RESET = 2'h0;

endpackage : prd_pkg

// ---- logic/prd_decode.sv ----
// Pulse decoder: turns two reference pins into forward and reverse count pulses.
// Assumes pins are synchronous to clk and fmt is stable during operation.
`timescale 1ns/1ps
module prd_decode (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] fmt,
  input wire logic pin_a,
  input wire logic pin_b,
  output logic fwd,
  output logic rev,
  output logic [1:0] step
);

  logic [1:0] prev_q;
  logic [1:0] prev_d;
  logic a_n;
  logic b_n;
  logic a_rise;
  logic b_rise;
  logic [1:0] cur;

  always_comb begin
    prev_d = {pin_b, pin_a};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      prev_q <= prd_pkg::PIN_RESET;
    end else begin
      prev_q <= prev_d;
    end
  end

  always_comb begin
    cur = {pin_b, pin_a};
    a_n = (fmt == prd_pkg::FMT_STEP_DIR_NEG) || (fmt == prd_pkg::FMT_FWD_REV_NEG);
    b_n = a_n;
    a_rise = a_n ? (prev_q[0] && !pin_a) : (!prev_q[0] && pin_a);
    b_rise = b_n ? (prev_q[1] && !pin_b) : (!prev_q[1] && pin_b);
    fwd = 1'b0;
    rev = 1'b0;
    step = 2'h1;
    unique case (fmt)
      prd_pkg::FMT_STEP_DIR_POS, prd_pkg::FMT_STEP_DIR_NEG: begin
        // Pin a carries steps, pin b the direction level.
        fwd = a_rise && !(pin_b ^ b_n);
        rev = a_rise && (pin_b ^ b_n);
      end
      prd_pkg::FMT_FWD_REV_POS, prd_pkg::FMT_FWD_REV_NEG: begin
        fwd = a_rise && !b_rise;
        rev = b_rise && !a_rise;
      end
      prd_pkg::FMT_QUAD_X1, prd_pkg::FMT_QUAD_X2, prd_pkg::FMT_QUAD_X4: begin
        // Gray sequence 00-01-11-10 is forward (a leads b).
        if (cur != prev_q) begin
          fwd = (prev_q == 2'h0 && cur == 2'h1) || (prev_q == 2'h1 && cur == 2'h3) ||
                (prev_q == 2'h3 && cur == 2'h2) || (prev_q == 2'h2 && cur == 2'h0);
          rev = (prev_q == 2'h0 && cur == 2'h2) || (prev_q == 2'h2 && cur == 2'h3) ||
                (prev_q == 2'h3 && cur == 2'h1) || (prev_q == 2'h1 && cur == 2'h0);
          if (fmt == prd_pkg::FMT_QUAD_X1) begin
            fwd = fwd && prev_q == 2'h0;
            rev = rev && cur == 2'h0;
          end else if (fmt == prd_pkg::FMT_QUAD_X2) begin
            // Both edges of pin a count, giving two counts per cycle.
            fwd = fwd && cur[0] != prev_q[0];
            rev = rev && cur[0] != prev_q[0];
          end
        end
      end
      default: begin
        fwd = 1'b0;
        rev = 1'b0;
      end
    endcase
  end

endmodule : prd_decode

// ---- logic/prd_top.sv ----
// Pulse reference decoder top: deviation counter with clear and alarm handling.
// Assumes all inputs synchronous to clk; settings change only while idle.
`timescale 1ns/1ps
module prd_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] fmt,
  input wire logic [1:0] clr_mode,
  input wire logic [1:0] alm_opt,
  input wire logic pin_a,
  input wire logic pin_b,
  input wire logic clr_in,
  input wire logic alarm,
  output logic [31:0] deviation,
  output logic cleared
);

  logic fwd;
  logic rev;
  logic [1:0] unused_step;
  logic [31:0] dev_q;
  logic [31:0] dev_d;
  logic clr_prev_q;
  logic clr_prev_d;
  logic cleared_q;
  logic cleared_d;
  logic clear_now;

  prd_decode u_dec (
    .clk(clk),
    .rst(rst),
    .fmt(fmt),
    .pin_a(pin_a),
    .pin_b(pin_b),
    .fwd(fwd),
    .rev(rev),
    .step(unused_step)
  );

  always_comb begin
    clr_prev_d = clr_in;
    clear_now = 1'b0;
    unique case (clr_mode)
      prd_pkg::CLR_WHILE_ON: clear_now = clr_in;
      prd_pkg::CLR_ON_RISE: clear_now = clr_in && !clr_prev_q;
      prd_pkg::CLR_WHILE_OFF: clear_now = !clr_in;
      default: clear_now = 1'b0;
    endcase
    if (alarm && alm_opt == prd_pkg::ALM_CLEARS) begin
      clear_now = 1'b1;
    end
    dev_d = dev_q;
    if (clear_now) begin
      dev_d = prd_pkg::DEV_RESET;
    end else if (fwd) begin
      dev_d = dev_q + 32'h0000_0001;
    end else if (rev) begin
      dev_d = dev_q - 32'h0000_0001;
    end
    cleared_d = clear_now;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dev_q <= prd_pkg::DEV_RESET;
      clr_prev_q <= 1'b0;
      cleared_q <= 1'b0;
    end else begin
      dev_q <= dev_d;
      clr_prev_q <= clr_prev_d;
      cleared_q <= cleared_d;
    end
  end

  assign deviation = dev_q;
  assign cleared = cleared_q;

  AST_CLR_ON: assert property (@(posedge clk) disable iff (rst)
    clr_mode == prd_pkg::CLR_WHILE_ON && clr_in |=> deviation == 32'h0000_0000)
    else $error("Deviation not held at zero while clear high.");
  AST_CLR_EDGE: assert property (@(posedge clk) disable iff (rst)
    clr_mode == prd_pkg::CLR_ON_RISE && clr_in && !$past(clr_in) |=> deviation == 32'h0000_0000)
    else $error("Deviation not zeroed on clear edge.");
  AST_CLR_OFF: assert property (@(posedge clk) disable iff (rst)
    clr_mode == prd_pkg::CLR_WHILE_OFF && !clr_in |=> deviation == 32'h0000_0000)
    else $error("Deviation not held at zero while clear low.");
  AST_ALM_KEEP: assert property (@(posedge clk) disable iff (rst)
    alarm && alm_opt == prd_pkg::ALM_KEEPS && !clear_now && !fwd && !rev |=> $stable(deviation))
    else $error("Deviation changed on alarm with keep option.");
  AST_ALM_CLR: assert property (@(posedge clk) disable iff (rst)
    alarm && alm_opt == prd_pkg::ALM_CLEARS |=> deviation == 32'h0000_0000)
    else $error("Alarm did not zero deviation.");
  AST_FWD: assert property (@(posedge clk) disable iff (rst)
    fwd && !clear_now |=> deviation == $past(deviation) + 32'h0000_0001)
    else $error("Forward count not added.");
  AST_REV: assert property (@(posedge clk) disable iff (rst)
    rev && !fwd && !clear_now |=> deviation == $past(deviation) - 32'h0000_0001)
    else $error("Reverse count not subtracted.");
  AST_STEP_DIR: assert property (@(posedge clk) disable iff (rst)
    fmt == prd_pkg::FMT_STEP_DIR_POS && pin_a && !$past(pin_a) && !pin_b |-> fwd && !rev)
    else $error("Step with direction low not forward.");
  AST_FWD_REV: assert property (@(posedge clk) disable iff (rst)
    fmt == prd_pkg::FMT_FWD_REV_POS && pin_b && !$past(pin_b) && !(pin_a && !$past(pin_a)) |-> rev)
    else $error("Reverse pulse not counted.");
  AST_NEG: assert property (@(posedge clk) disable iff (rst)
    fmt == prd_pkg::FMT_STEP_DIR_NEG && !pin_a && $past(pin_a) && pin_b |-> fwd)
    else $error("Negative logic step not forward.");
  AST_QX4: assert property (@(posedge clk) disable iff (rst)
    fmt == prd_pkg::FMT_QUAD_X4 && $past({pin_b, pin_a}) == 2'h1 && {pin_b, pin_a} == 2'h3 |-> fwd)
    else $error("Quadrature x4 missed a count.");

  COV_FWD: cover property (@(posedge clk) disable iff (rst) fwd);
  COV_REV: cover property (@(posedge clk) disable iff (rst) rev);
  COV_CLR: cover property (@(posedge clk) disable iff (rst) clear_now && deviation != 32'h0000_0000);

endmodule : prd_top

// ---- tb/prd_host.sv ----
// Host pulse source model that drives the two reference pins.
// Assumes the bench calls its tasks; the pins change at the falling clk edge.
`timescale 1ns/1ps
module prd_host (
  input wire logic clk,
  input wire logic [3:0] fmt,
  output logic pin_a,
  output logic pin_b
);
  int ph = 0;
  logic ng;
  assign ng = (fmt == prd_pkg::FMT_STEP_DIR_NEG) || (fmt == prd_pkg::FMT_FWD_REV_NEG);
  initial begin
    pin_a = 1'b0;
    pin_b = 1'b0;
  end
  task automatic idle();
    @(negedge clk);
    pin_a = ng;
    pin_b = ng;
    ph = 0;
  endtask : idle
  // Moves one count, or one quarter cycle in the quadrature forms.
  task automatic step(input bit d);
    @(negedge clk);
    if (fmt == 4'h0 || fmt == 4'h5) begin
      pin_b = d ? ng : !ng;
      @(negedge clk);
      pin_a = !ng;
      @(negedge clk);
      pin_a = ng;
    end else if (fmt == 4'h1 || fmt == 4'h6) begin
      if (d) pin_a = !ng;
      else pin_b = !ng;
      @(negedge clk);
      pin_a = ng;
      pin_b = ng;
    end else begin
      ph = d ? (ph + 1) % 4 : (ph + 3) % 4;
      pin_a = (ph == 1) || (ph == 2);
      pin_b = ph >= 2;
    end
  endtask : step
endmodule : prd_host

// ---- tb/testbench.sv ----
// Self-checking bench for the pulse reference decoder top.
// Assumes one 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, clr_in = 1'b0, alarm = 1'b0, pin_a, pin_b, cleared;
  logic [3:0] fmt = 4'h0;
  logic [1:0] clr_mode = 2'h0, alm_opt = 2'h1;
  logic [31:0] deviation, seed = 32'h4BAF;
  int fails = 0, total_checks = 0, exp = 0;
  prd_top DUT (.clk(clk), .rst(rst), .fmt(fmt), .clr_mode(clr_mode), .alm_opt(alm_opt), .pin_a(pin_a),
    .pin_b(pin_b), .clr_in(clr_in), .alarm(alarm), .deviation(deviation), .cleared(cleared));
  prd_host host (.clk(clk), .fmt(fmt), .pin_a(pin_a), .pin_b(pin_b));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] e, input logic [31:0] a);
    total_checks++;
    if (a !== e) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : chk
  task automatic summarize();
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic zero();
    clr_mode = prd_pkg::CLR_WHILE_ON;
    clr_in = 1'b1;
    cyc(2);
    exp = 0;
    chk(32'h0, deviation);
    chk(32'h1, {31'h0, cleared});
    clr_in = 1'b0;
  endtask : zero
  // One full quadrature cycle, or one pulse in the other forms.
  task automatic go(input bit d);
    int m;
    m = (fmt >= 2 && fmt <= 4) ? 4 : 1;
    repeat (m) host.step(d);
    exp += (d ? 1 : -1) * ((m == 4) ? (1 << (fmt - 2)) : 1);
    cyc(2);
  endtask : go
  initial begin
    #200us;
    fails++;
    summarize();
  end
  initial begin
    cyc(2);
    rst = 1'b0;
    for (int f = 0; f < 7; f++) begin
      fmt = f[3:0];
      host.idle();
      zero();
      for (int k = 0; k < 6; k++) begin
        seed = lfsr(seed);
        go(seed[0]);
        chk(exp, deviation);
      end
    end
    fmt = prd_pkg::FMT_STEP_DIR_POS;
    host.idle();
    zero();
    go(1);
    go(1);
    clr_mode = prd_pkg::CLR_ON_RISE;
    clr_in = 1'b1;
    cyc(2);
    exp = 0;
    chk(exp, deviation);
    go(1);
    chk(exp, deviation);
    clr_mode = prd_pkg::CLR_WHILE_OFF;
    clr_in = 1'b0;
    go(1);
    exp = 0;
    chk(exp, deviation);
    clr_in = 1'b1;
    go(0);
    chk(exp, deviation);
    alarm = 1'b1;
    cyc(2);
    chk(exp, deviation);
    alm_opt = prd_pkg::ALM_CLEARS;
    cyc(2);
    exp = 0;
    chk(exp, deviation);
    alarm = 1'b0;
    go(1);
    chk(exp, deviation);
    clr_mode = 2'h3;
    clr_in = 1'b0;
    fmt = 4'h7;
    repeat (4) host.step(1'b1);
    cyc(2);
    chk(exp, deviation);
    summarize();
  end
endmodule : testbench
